// >>> srwc_clk_source.sv
`timescale 1ns/1ps
module srwc_clk_source #(
    parameter int PERIOD = 8,
    parameter int ALIGN0 = 1317,
    parameter int ALIGN1 = 968
) (
    input  wire logic        core_clk,     // Device clock
    input  wire logic        rst,          // Async reset, high
    input  wire logic        run,          // Reference running
    input  wire logic [4:0]  edge_pos,     // Tap where the rising edge lands
    input  wire logic        delay_inv,    // Applied invert delay
    input  wire logic [7:0]  delay_coarse, // Applied coarse delay
    input  wire logic [7:0]  delay_fine,   // Applied fine delay
    output logic      [23:0] ref_taps,     // Reference at delayed taps
    output logic             ref_at_fall   // Phase detector
);
    int          ph;
    logic [23:0] rise;
    logic [23:0] ramp;

    assign ramp = ~((24'h000001 << edge_pos) - 24'h000001);
    // Periodic for as long as run stays high, never a lone pulse
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ph <= 0;
            rise <= 24'h000000;
            ref_taps <= 24'h000000;
        end else if (!run) begin
            ph <= 0;
            ref_taps <= 24'h000000;
        end else begin
            ph <= (ph == PERIOD - 1) ? 0 : ph + 1;
            if (ph == 0) begin
                rise <= ramp;
                ref_taps <= ramp;
            end else if (ph < 4) begin
                ref_taps <= 24'hffffff;
            end else if (ph == 4) begin
                ref_taps <= ~rise;
            end else begin
                ref_taps <= 24'h000000;
            end
        end
    end
    // Falling edge meets the reference edge once the applied delay reaches the alignment point
    assign ref_at_fall = run && ({delay_coarse, delay_fine} >= (delay_inv ? ALIGN1 : ALIGN0));
endmodule  // srwc_clk_source

// >>> srwc_defs.svh
`ifndef SRWC_DEFS_SVH
`define SRWC_DEFS_SVH

// Register indices; byte address is four times the index
`define SRWC_IDX_CTRL    8'h29
`define SRWC_IDX_EN      8'h2a
`define SRWC_IDX_SETUP   8'h2b
`define SRWC_IDX_POS_LO  8'h2c
`define SRWC_IDX_POS_MID 8'h2d
`define SRWC_IDX_POS_HI  8'h2e
`define SRWC_IDX_STAT    8'h2f
`define SRWC_IDX_RES     8'h30
`define SRWC_IDX_DLY     8'h31

// Field positions
`define SRWC_CTRL_FINE   4
`define SRWC_SETUP_FINE  0
`define SRWC_STAT_DONE   0
`define SRWC_STAT_VALID  1
`define SRWC_STAT_BUSY   2
`define SRWC_DLY_INV     16

// Reset values
`define SRWC_CTRL_RST    5'h00
`define SRWC_SETUP_RST   8'h01
`define SRWC_DLY_RST     17'h00000

// Sizes and timing
`define SRWC_POS_N       24
`define SRWC_REF_EDGES   3
`define SRWC_CLK_NS      40
`define SRWC_SETTLE_NS   640
`define SRWC_SETTLE_CYC  ((`SRWC_SETTLE_NS + `SRWC_CLK_NS - 1) / `SRWC_CLK_NS)
`endif

// >>> srwc_det_if.sv
`timescale 1ns/1ps
interface srwc_det_if #(parameter int N = 24);
    logic [N-1:0] taps;
    logic [N-1:0] map;
    logic         valid;
    modport det (input taps, output map, output valid);
    modport ctl (output taps, input map, input valid);
endinterface

// >>> srwc_pkg.sv
package srwc_pkg;
    typedef enum logic [2:0] {
        CAL_IDLE  = 3'b000,
        CAL_SWEEP = 3'b001,
        CAL_PICK  = 3'b010,
        CAL_FINE  = 3'b011,
        CAL_DONE  = 3'b100
    } srwc_cal_t;

    typedef struct packed {
        logic        wreq;
        logic [31:0] rdata;
        logic [3:0]  sel;
        logic        fine_step;
        logic        en;
        logic        en_d;
        logic [7:0]  setup;
        logic        done;
        logic [16:0] res;
        logic [16:0] dly;
        logic [16:0] apply;
        srwc_cal_t   cal;
        logic        inv;
        logic [7:0]  coarse;
        logic [7:0]  fine;
        logic [7:0]  cnt;
        logic [7:0]  best0;
        logic        cap;
    } srwc_state_t;
endpackage

// >>> srwc_pos_detect.sv
`timescale 1ns/1ps
`include "srwc_defs.svh"
module srwc_pos_detect #(
    parameter int N     = `SRWC_POS_N,
    parameter int EDGES = `SRWC_REF_EDGES
) (
    input wire logic clk,  // Device clock
    input wire logic rst,  // Async reset, high
    srwc_det_if.det  dif   // Taps in, map out
);
    typedef struct packed {
        logic [N-1:0] acc;
        logic [N-1:0] map;
        logic         valid;
        logic [1:0]   edges;
        logic         prev;
    } srwc_det_t;

    srwc_det_t    st_r;
    srwc_det_t    st_nxt;
    logic [N-1:0] risk;
    logic         ref_rise;

    always_comb begin
        risk = '0;
        // A level change between neighbours marks both as near the reference edge
        for (int i = 0; i < N - 1; i++) begin
            if (dif.taps[i] ^ dif.taps[i+1]) begin
                risk[i]   = 1'b1;
                risk[i+1] = 1'b1;
            end
        end
        ref_rise     = dif.taps[0] && !st_r.prev;
        st_nxt       = st_r;
        st_nxt.prev  = dif.taps[0];
        st_nxt.acc   = st_r.acc | risk;
        if (ref_rise) begin
            if (st_r.edges == 2'(EDGES - 1)) begin
                st_nxt.map      = st_r.acc | risk;
                st_nxt.map[0]   = 1'b1;
                st_nxt.map[N-1] = 1'b1;
                st_nxt.valid    = 1'b1;
                st_nxt.acc      = '0;
                st_nxt.edges    = 2'd0;
            end else begin
                st_nxt.edges = st_r.edges + 2'd1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dif.map   = st_r.map;
    assign dif.valid = st_r.valid;

    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);

    ends_flagged_a: assert property (dif.valid |-> dif.map[0] && dif.map[N-1])
        else $error("edge positions not flagged");
    valid_edges_a: assert property ($rose(dif.valid) |-> $past(ref_rise) && $past(st_r.edges) == 2'(EDGES - 1))
        else $error("map valid before enough reference edges");
    risk_kept_a: assert property (ref_rise && st_r.edges == 2'(EDGES - 1) |=> (dif.map & $past(risk)) == $past(risk))
        else $error("risky position not flagged");
    map_valid_c: cover property ($rose(dif.valid));
endmodule // srwc_pos_detect

// >>> srwc_top.sv
`timescale 1ns/1ps
`include "srwc_defs.svh"
module srwc_top #(
    parameter int ADDR_W     = 10,
    parameter int SETTLE_CYC = `SRWC_SETTLE_CYC
) (
    input  wire logic              core_clk,         // Device clock, 25 MHz
    input  wire logic              rst,              // Async reset, high
    input  wire logic [ADDR_W-1:0] avs_address,      // Byte address
    input  wire logic              avs_read,         // Read request
    input  wire logic              avs_write,        // Write request
    input  wire logic [31:0]       avs_writedata,    // Write data
    input  wire logic [3:0]        avs_byteenable,   // Byte lanes
    output logic      [31:0]       avs_readdata,     // Read data
    output logic                   avs_waitrequest,  // Stall
    input  wire logic [23:0]       ref_taps,         // Reference at 24 delayed clocks
    input  wire logic              ref_at_fall,      // Reference seen high at clock falling edge
    output logic                   ref_capture,      // Reference at selected position
    output logic                   step_fine,        // Position step size
    output logic                   delay_inv,        // Clock invert delay
    output logic      [7:0]        delay_coarse,     // Coarse aperture delay
    output logic      [7:0]        delay_fine        // Fine aperture delay
);
    localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYC - 1);
    localparam logic [7:0] STEP_LAST   = 8'hff;

    srwc_pkg::srwc_state_t st_r;
    srwc_pkg::srwc_state_t st_nxt;
    srwc_det_if #(.N(`SRWC_POS_N)) dif ();

    logic [7:0]  idx;
    logic        req;
    logic        wr_ok;
    logic        sel_tap;
    logic        step_end;
    logic [31:0] rd_val;

    assign dif.taps = ref_taps;

    srwc_pos_detect #(
        .N     (`SRWC_POS_N),
        .EDGES (`SRWC_REF_EDGES)
    ) u_det (
        .clk (core_clk),
        .rst (rst),
        .dif (dif)
    );

    assign idx      = avs_address[9:2];
    assign req      = avs_read || avs_write;
    assign wr_ok    = avs_write && !st_r.wreq;
    assign sel_tap  = ref_taps[st_r.sel];
    assign step_end = st_r.cnt == SETTLE_LAST;

    always_comb begin
        if (idx == `SRWC_IDX_POS_LO) begin
            rd_val = {24'h000000, dif.map[7:0]};
        end else if (idx == `SRWC_IDX_POS_MID) begin
            rd_val = {24'h000000, dif.map[15:8]};
        end else if (idx == `SRWC_IDX_POS_HI) begin
            rd_val = {24'h000000, dif.map[23:16]};
        end else if (idx == `SRWC_IDX_CTRL) begin
            rd_val = {27'h0000000, st_r.fine_step, st_r.sel};
        end else if (idx == `SRWC_IDX_EN) begin
            rd_val = {31'h00000000, st_r.en};
        end else if (idx == `SRWC_IDX_SETUP) begin
            rd_val = {24'h000000, st_r.setup};
        end else if (idx == `SRWC_IDX_STAT) begin
            rd_val = {29'h00000000, st_r.cal != srwc_pkg::CAL_IDLE, dif.valid, st_r.done};
        end else if (idx == `SRWC_IDX_RES) begin
            rd_val = {15'h0000, st_r.res};
        end else if (idx == `SRWC_IDX_DLY) begin
            rd_val = {15'h0000, st_r.dly};
        end else begin
            rd_val = 32'h00000000;
        end
    end

    always_comb begin
        st_nxt      = st_r;
        // One wait cycle per access; the write lands on the edge that sees it low
        st_nxt.wreq = !(req && st_r.wreq);
        if (avs_read && st_r.wreq) begin
            st_nxt.rdata = rd_val;
        end
        if (wr_ok) begin
            if (idx == `SRWC_IDX_CTRL && avs_byteenable[0]) begin
                st_nxt.sel       = avs_writedata[3:0];
                st_nxt.fine_step = avs_writedata[`SRWC_CTRL_FINE];
            end else if (idx == `SRWC_IDX_EN && avs_byteenable[0]) begin
                st_nxt.en = avs_writedata[0];
            end else if (idx == `SRWC_IDX_SETUP && avs_byteenable[0]) begin
                st_nxt.setup = avs_writedata[7:0];
            end else if (idx == `SRWC_IDX_DLY) begin
                if (avs_byteenable[0]) begin
                    st_nxt.dly[7:0] = avs_writedata[7:0];
                end
                if (avs_byteenable[1]) begin
                    st_nxt.dly[15:8] = avs_writedata[15:8];
                end
                if (avs_byteenable[2]) begin
                    st_nxt.dly[`SRWC_DLY_INV] = avs_writedata[`SRWC_DLY_INV];
                end
            end
        end

        st_nxt.en_d = st_r.en;
        st_nxt.cap  = sel_tap;

        case (st_r.cal)
            srwc_pkg::CAL_IDLE: begin
                if (st_r.en && !st_r.en_d) begin
                    st_nxt.done   = 1'b0;
                    st_nxt.cal    = srwc_pkg::CAL_SWEEP;
                    st_nxt.inv    = 1'b0;
                    st_nxt.coarse = 8'h00;
                    st_nxt.fine   = 8'h00;
                    st_nxt.cnt    = 8'h00;
                end
            end
            srwc_pkg::CAL_SWEEP: begin
                // Each step waits for the delay line and the reference to settle
                if (step_end) begin
                    st_nxt.cnt = 8'h00;
                    if (ref_at_fall || st_r.coarse == STEP_LAST) begin
                        if (!st_r.inv) begin
                            st_nxt.best0  = st_r.coarse;
                            st_nxt.inv    = 1'b1;
                            st_nxt.coarse = 8'h00;
                        end else begin
                            st_nxt.cal = srwc_pkg::CAL_PICK;
                        end
                    end else begin
                        st_nxt.coarse = st_r.coarse + 8'h01;
                    end
                end else begin
                    st_nxt.cnt = st_r.cnt + 8'h01;
                end
            end
            srwc_pkg::CAL_PICK: begin
                // Less coarse delay means less clock path loss; ties keep invert off
                if (st_r.best0 <= st_r.coarse) begin
                    st_nxt.inv    = 1'b0;
                    st_nxt.coarse = st_r.best0;
                end
                st_nxt.fine = 8'h00;
                st_nxt.cnt  = 8'h00;
                if (st_r.setup[`SRWC_SETUP_FINE]) begin
                    // Back off one coarse step so the fine sweep brackets the edge
                    if (st_nxt.coarse != 8'h00) begin
                        st_nxt.coarse = st_nxt.coarse - 8'h01;
                    end
                    st_nxt.cal = srwc_pkg::CAL_FINE;
                end else begin
                    st_nxt.cal = srwc_pkg::CAL_DONE;
                end
            end
            srwc_pkg::CAL_FINE: begin
                if (step_end) begin
                    st_nxt.cnt = 8'h00;
                    if (ref_at_fall || st_r.fine == STEP_LAST) begin
                        st_nxt.cal = srwc_pkg::CAL_DONE;
                    end else begin
                        st_nxt.fine = st_r.fine + 8'h01;
                    end
                end else begin
                    st_nxt.cnt = st_r.cnt + 8'h01;
                end
            end
            srwc_pkg::CAL_DONE: begin
                st_nxt.res  = {st_r.inv, st_r.coarse, st_r.fine};
                st_nxt.dly  = {st_r.inv, st_r.coarse, st_r.fine};
                st_nxt.done = 1'b1;
                st_nxt.cal  = srwc_pkg::CAL_IDLE;
            end
            default: begin
                st_nxt.cal = srwc_pkg::CAL_IDLE;
            end
        endcase

        // Dropping enable mid-search abandons it and leaves done low
        if (!st_r.en && st_r.cal != srwc_pkg::CAL_IDLE) begin
            st_nxt.cal = srwc_pkg::CAL_IDLE;
        end

        // Invert, coarse and fine drive the delay line independently
        if (st_nxt.cal == srwc_pkg::CAL_IDLE) begin
            st_nxt.apply = st_nxt.dly;
        end else begin
            st_nxt.apply = {st_nxt.inv, st_nxt.coarse, st_nxt.fine};
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_r           <= '0;
            st_r.wreq      <= 1'b1;
            {st_r.fine_step, st_r.sel} <= `SRWC_CTRL_RST;
            st_r.setup     <= `SRWC_SETUP_RST;
            st_r.dly       <= `SRWC_DLY_RST;
            st_r.apply     <= `SRWC_DLY_RST;
            st_r.cal       <= srwc_pkg::CAL_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign avs_readdata    = st_r.rdata;
    assign avs_waitrequest = st_r.wreq;
    assign ref_capture     = st_r.cap;
    assign step_fine       = st_r.fine_step;
    assign delay_inv       = st_r.apply[`SRWC_DLY_INV];
    assign delay_coarse    = st_r.apply[15:8];
    assign delay_fine      = st_r.apply[7:0];

    default clocking dc @(posedge core_clk); endclocking
    default disable iff (rst);

    bus_answer_a: assert property (req && st_r.wreq |=> !avs_waitrequest)
        else $error("bus access not answered after one wait");
    capture_sel_a: assert property (1'b1 |=> ref_capture == $past(sel_tap))
        else $error("capture not from selected position");
    step_write_a: assert property (wr_ok && idx == `SRWC_IDX_CTRL && avs_byteenable[0]
            |=> step_fine == $past(avs_writedata[`SRWC_CTRL_FINE]))
        else $error("step size not taken from write");
    done_clear_a: assert property ($rose(st_r.en) && st_r.cal == srwc_pkg::CAL_IDLE |-> ##2 !st_r.done)
        else $error("done not cleared on new start");
    result_copy_a: assert property ($rose(st_r.done) |-> st_r.res == st_r.dly
            && $past(st_r.cal) == srwc_pkg::CAL_DONE)
        else $error("result not published with done");
    hold_delay_a: assert property (st_r.cal == srwc_pkg::CAL_IDLE
            |-> {delay_inv, delay_coarse, delay_fine} == st_r.dly)
        else $error("idle delay differs from stored delay");
    pick_smaller_a: assert property (st_r.cal == srwc_pkg::CAL_PICK
            |=> st_r.inv == ($past(st_r.coarse) < $past(st_r.best0)))
        else $error("polarity with larger coarse chosen");
    stop_aligned_a: assert property (st_r.cal == srwc_pkg::CAL_SWEEP && step_end && ref_at_fall && !st_r.inv
            |=> st_r.inv && st_r.coarse == 8'h00)
        else $error("sweep did not stop at alignment");

    cal_done_c: cover property (st_r.cal == srwc_pkg::CAL_DONE);
    inv_win_c: cover property (st_r.cal == srwc_pkg::CAL_PICK ##1 st_r.inv);
    ctrl_write_c: cover property (wr_ok && idx == `SRWC_IDX_CTRL);
endmodule // srwc_top

// >>> sysref_window_and_autocal_bench.sv
`timescale 1ns/1ps
`include "srwc_defs.svh"
module sysref_window_and_autocal_bench;
    localparam int A0 = 1317;
    localparam int A1 = 968;
    logic        core_clk, rst, avs_read, avs_write, run, ref_at_fall, ref_capture, step_fine;
    logic        avs_waitrequest, delay_inv;
    logic [9:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0]  avs_byteenable;
    logic [23:0] ref_taps, taps_q;
    logic [7:0]  delay_coarse, delay_fine;
    logic [4:0]  edge_pos;
    logic [16:0] dly_m;
    logic [31:0] dly_o;
    int          err_total, num_checks, seed, p;

    assign dly_o = {15'h0, delay_inv, delay_coarse, delay_fine};

    srwc_top #(.ADDR_W(10), .SETTLE_CYC(2)) srwc_top_i (.core_clk, .rst, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .ref_taps,
        .ref_at_fall, .ref_capture, .step_fine, .delay_inv, .delay_coarse, .delay_fine);
    srwc_clk_source #(.ALIGN0(A0), .ALIGN1(A1)) srwc_clk_source_i (.core_clk, .rst, .run, .edge_pos,
        .delay_inv, .delay_coarse, .delay_fine, .ref_taps, .ref_at_fall);

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) taps_q <= ref_taps;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Slave answer time is checked to be two edges; only the bound catches a hang
    task automatic bus(input bit wr, input logic [7:0] idx, input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= d;
        avs_byteenable <= be;
        if (wr) avs_write <= 1'b1;
        else avs_read <= 1'b1;
        // Only the watchdog ends a wait that never gets its answer
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        check("wait_cycles", n, 32'd2);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0, 4'hf);
        check(name, rd, exp);
    endtask

    task automatic map_chk(input logic [23:0] exp);
        rd_chk("map_lo", `SRWC_IDX_POS_LO, {24'h0, exp[7:0]});
        rd_chk("map_mid", `SRWC_IDX_POS_MID, {24'h0, exp[15:8]});
        rd_chk("map_hi", `SRWC_IDX_POS_HI, {24'h0, exp[23:16]});
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        do begin
            bus(1'b0, `SRWC_IDX_STAT, 32'h0, 4'hf);
            n++;
        end while (rd[0] !== 1'b1 && n < 600);
        check("done", {31'h0, rd[0]}, 32'h1);
    endtask

    function automatic logic [23:0] map_exp(input int q);
        return 24'h800001 | (24'h000001 << q) | (24'h000001 << (q - 1));
    endfunction

    // Coarse sweep per polarity, smaller coarse kept, inv0 on a tie, then optional fine sweep
    function automatic logic [16:0] cal_exp(input bit fine_on);
        int c0, c1, c, f, a;
        c0 = 0;
        while (c0 < 255 && c0 * 256 < A0) c0++;
        c1 = 0;
        while (c1 < 255 && c1 * 256 < A1) c1++;
        c = (c1 < c0) ? c1 : c0;
        a = (c1 < c0) ? A1 : A0;
        f = 0;
        if (fine_on) begin
            if (c > 0) c--;
            while (f < 255 && c * 256 + f < a) f++;
        end
        return {c1 < c0, c[7:0], f[7:0]};
    endfunction

    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        end_of_test();
    end

    initial begin
        seed = 94;
        rst = 1'b1;
        run = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 10'h000;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        edge_pos = 5'h01;
        err_total = 0;
        num_checks = 0;
        repeat (5) @(posedge core_clk);
        check("rst_delay", dly_o, 32'h0);
        rst <= 1'b0;
        rd_chk("ctrl", `SRWC_IDX_CTRL, 32'h0);
        rd_chk("setup", `SRWC_IDX_SETUP, 32'h1);
        rd_chk("stat", `SRWC_IDX_STAT, 32'h0);
        map_chk(24'h0);
        bus(1'b1, 8'h40, 32'hffffffff, 4'hf);
        rd_chk("unmapped", 8'h40, 32'h0);
        // A 25 MHz device clock is far below 3GHz, so coarse position steps
        bus(1'b1, `SRWC_IDX_CTRL, 32'h0, 4'h1);
        p = 1 + (($random(seed) & 32'h7fffffff) % 23);
        edge_pos <= p[4:0];
        run <= 1'b1;
        cyc(8);
        rd_chk("stat_early", `SRWC_IDX_STAT, 32'h0);
        cyc(40);
        bus(1'b1, `SRWC_IDX_POS_LO, 32'h0, 4'hf);
        map_chk(map_exp(p));
        rd_chk("stat_valid", `SRWC_IDX_STAT, 32'h2);
        p = 1 + (($random(seed) & 32'h7fffffff) % 23);
        edge_pos <= p[4:0];
        cyc(80);
        map_chk(map_exp(p));
        for (int s = 0; s < 16; s++) begin
            bus(1'b1, `SRWC_IDX_CTRL, {27'h0, s[0], s[3:0]}, 4'h1);
            cyc(2);
            check("step_fine", {31'h0, step_fine}, {31'h0, s[0]});
            for (int k = 0; k < 8; k++) begin
                @(negedge core_clk);
                check("capture", {31'h0, ref_capture}, {31'h0, taps_q[s]});
            end
        end
        dly_m = 17'($random(seed));
        bus(1'b1, `SRWC_IDX_DLY, {15'h0, dly_m}, 4'h7);
        rd_chk("dly", `SRWC_IDX_DLY, {15'h0, dly_m});
        check("dly_out", dly_o, {15'h0, dly_m});
        bus(1'b1, `SRWC_IDX_DLY, 32'h1ffff, 4'h1);
        dly_m[7:0] = 8'hff;
        rd_chk("dly_lane", `SRWC_IDX_DLY, {15'h0, dly_m});
        bus(1'b1, `SRWC_IDX_CTRL, 32'h0, 4'h1);
        bus(1'b1, `SRWC_IDX_SETUP, 32'h1, 4'h1);
        bus(1'b1, `SRWC_IDX_EN, 32'h1, 4'h1);
        rd_chk("busy", `SRWC_IDX_STAT, 32'h6);
        wait_done();
        rd_chk("result", `SRWC_IDX_RES, {15'h0, cal_exp(1'b1)});
        rd_chk("dly_cal", `SRWC_IDX_DLY, {15'h0, cal_exp(1'b1)});
        check("dly_out_cal", dly_o, {15'h0, cal_exp(1'b1)});
        check("aligned", {31'h0, ref_at_fall}, 32'h1);
        bus(1'b1, `SRWC_IDX_EN, 32'h0, 4'h1);
        bus(1'b1, `SRWC_IDX_EN, 32'h1, 4'h1);
        rd_chk("restart", `SRWC_IDX_STAT, 32'h6);
        bus(1'b1, `SRWC_IDX_EN, 32'h0, 4'h1);
        cyc(3);
        rd_chk("abort", `SRWC_IDX_STAT, 32'h2);
        check("dly_out_abort", dly_o, {15'h0, cal_exp(1'b1)});
        bus(1'b1, `SRWC_IDX_SETUP, 32'h0, 4'h1);
        bus(1'b1, `SRWC_IDX_EN, 32'h1, 4'h1);
        wait_done();
        rd_chk("result_coarse", `SRWC_IDX_RES, {15'h0, cal_exp(1'b0)});
        bus(1'b1, `SRWC_IDX_EN, 32'h0, 4'h1);
        dly_m = 17'($random(seed));
        bus(1'b1, `SRWC_IDX_DLY, {15'h0, dly_m}, 4'hf);
        cyc(2);
        check("override", dly_o, {15'h0, dly_m});
        end_of_test();
    end
endmodule  // sysref_window_and_autocal_bench
